// >>> design/tac_pkg.sv
// shared constants and carrier types for the touch adc conversion control
package tac_pkg;

  // register addresses
  localparam logic [7:0]  ADDR_CTRL1  = 8'h01;
  localparam logic [7:0]  ADDR_CTRL2  = 8'h02;
  localparam logic [7:0]  ADDR_CTRL3  = 8'h03;

  // reset values
  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [15:0] CTRL2_RESET = 16'h4040;
  localparam logic [15:0] CTRL3_RESET = 16'h0000;

  // field positions, conversion_mode_control
  localparam int PEN_EN_BIT   = 15;
  localparam int CHAN_LSB     = 12;
  localparam int MODE_LSB     = 10;
  localparam int IVL_LSB      = 0;
  // field positions, power_filter_delay_config
  localparam int PWR_LSB      = 14;
  localparam int SE_BIT       = 9;
  localparam int SRST_BIT     = 4;
  localparam int FDLY_LSB     = 0;

  // conversion modes
  localparam logic [1:0] MODE_NONE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_SEQ_S  = 2'h2;
  localparam logic [1:0] MODE_SEQ_M  = 2'h3;

  // channel select codes; sequencer bit n selects code n
  localparam logic [2:0] CH_XPLATE   = 3'h7;
  localparam logic [2:0] CH_YPLATE   = 3'h6;
  localparam logic [2:0] CH_PRESS1   = 3'h5;
  localparam logic [2:0] CH_PRESS2   = 3'h4;
  localparam logic [2:0] CH_AUX      = 3'h3;
  localparam logic [2:0] CH_BATT     = 3'h2;
  localparam logic [2:0] CH_TEMP     = 3'h1;
  localparam logic [2:0] CH_INVALID  = 3'h0;
  localparam logic [7:0] SEQ_MASK    = 8'hFE;

  // timing figures
  localparam int unsigned CLK_FREQ_MHZ = 10;
  localparam int unsigned FDLY_UNIT_US  = 128;
  localparam int unsigned IVL_BASE_US   = 550;
  localparam int unsigned IVL_STEP_US   = 35;
  localparam int unsigned FDLY_UNIT_CYC = FDLY_UNIT_US * CLK_FREQ_MHZ;
  localparam int unsigned IVL_BASE_CYC  = IVL_BASE_US * CLK_FREQ_MHZ;
  localparam int unsigned IVL_STEP_CYC  = IVL_STEP_US * CLK_FREQ_MHZ;

  // first conversion delay in units of 128 us, indexed by the field
  localparam logic [5:0] FDLY_MULT [16] = '{6'h01, 6'h02, 6'h03, 6'h04,
                                            6'h05, 6'h06, 6'h07, 6'h08,
                                            6'h09, 6'h0A, 6'h0C, 6'h0E,
                                            6'h10, 6'h14, 6'h1C, 6'h20};

  // controller states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM  = 3'b001,
    ST_PRE  = 3'b010,
    ST_CONV = 3'b011,
    ST_POST = 3'b100,
    ST_WAIT = 3'b101,
    ST_NEXT = 3'b110
  } tac_state_type;

  // register access from the serial interface decoder
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tac_reg_req_type;

  // conversion request towards the converter core
  typedef struct packed {
    logic       start;
    logic [2:0] chan;
    logic       single_ended;
  } tac_conv_req_type;

endpackage : tac_pkg

// >>> design/tac_conv_ctrl.sv
// conversion control for the touch screen adc: modes, channels, delays, pen output
`timescale 1ns/1ns
// How it works
// - mode field selects idle, single, sequences
// - single mode converts channel field bits 14:12
// - single done: clear mode if timer zero
// - slave sequence converts each selected channel
// - sequence end: clear mode or rerun
// - master mode waits for touch first
// - master reruns on fresh touch or timer
// - channel codes map to plates and sensors
// - bit 9 picks single-ended or ratiometric
// - sequences use sequencer bits, ignore channel
// - bit 15 picks pen or limit output
// - delay field selects 128 us to 4.096 ms
// - delay before first, X/Y, after last
// - config register field layout, bit 15 down
// - config register resets to 0x4040
// - timer zero once, else 550 us plus 35 us steps
// - master timer stops on release
module tac_conv_ctrl
  import tac_pkg::*;
#(
  parameter int unsigned FDLY_UNIT_CYCLES = FDLY_UNIT_CYC,
  parameter int unsigned IVL_BASE_CYCLES  = IVL_BASE_CYC,
  parameter int unsigned IVL_STEP_CYCLES  = IVL_STEP_CYC
)
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire tac_reg_req_type  reg_req_in,
  output tac_conv_req_type      conv_req_out,
  input  wire logic             conv_done_in,
  input  wire logic             touch_in,
  input  wire logic             limit_alert_in,
  output logic [15:0]           reg_rdata_out,
  output logic                  busy_out,
  output logic                  pen_irq_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [15:0]      ctrl1_r;
  logic [15:0]      ctrl2_r;
  logic [15:0]      ctrl3_r;
  logic [19:0]      cnt_r;
  logic [19:0]      cnt_nxt;
  logic [7:0]       pend_r;
  logic [7:0]       pend_nxt;
  logic             first_r;
  logic             first_nxt;
  logic             clr_mode;
  tac_state_type    state_r;
  tac_state_type    state_nxt;
  tac_conv_req_type conv_r;
  tac_conv_req_type conv_nxt;
  logic             touch_s1_r;
  logic             touch_s2_r;
  logic             touch_d_r;
  logic [15:0]      rdata_r;
  logic             busy_r;
  logic             pen_n_r;

  // field views
  wire logic [1:0]  mode_f    = ctrl1_r[MODE_LSB +: 2];
  wire logic [2:0]  chan_f    = ctrl1_r[CHAN_LSB +: 3];
  wire logic [7:0]  ivl_f     = ctrl1_r[IVL_LSB +: 8];
  wire logic        pen_dis_f = ctrl1_r[PEN_EN_BIT];
  wire logic        se_f      = ctrl2_r[SE_BIT];
  wire logic [3:0]  fdly_f    = ctrl2_r[FDLY_LSB +: 4];
  wire logic [7:0]  seq_f     = ctrl3_r[7:0];

  // write strobes per register
  wire logic wr_c1 = reg_req_in.wr && (reg_req_in.addr == ADDR_CTRL1);
  wire logic wr_c2 = reg_req_in.wr && (reg_req_in.addr == ADDR_CTRL2);
  wire logic wr_c3 = reg_req_in.wr && (reg_req_in.addr == ADDR_CTRL3);

  // touch after the synchroniser and its fresh edge
  wire logic touch_s    = touch_s2_r;
  wire logic touch_rise = touch_s2_r && !touch_d_r;

  // highest pending channel wins, so X and Y come out first
  function automatic logic [2:0] top_chan(input logic [7:0] m);
    logic [2:0] c;
    c = CH_INVALID;
    for (int i = 1; i < 8; i++)
    begin
      if (m[i])
        c = 3'(i);
    end
    return c;
  endfunction : top_chan

  wire logic [2:0]  next_ch  = top_chan(pend_r);
  wire logic        pend_any = |(pend_r & SEQ_MASK);
  wire logic        is_xy    = (next_ch == CH_XPLATE) || (next_ch == CH_YPLATE);
  wire logic        need_dly = first_r || is_xy;
  // counter loads: a wait ends on the cycle it reads zero, so load length minus one
  wire logic [19:0] fdly_load = 20'(FDLY_UNIT_CYCLES * FDLY_MULT[fdly_f] - 32'd1);
  wire logic [19:0] ivl_load  = 20'(IVL_BASE_CYCLES - 32'd1 +
                                    IVL_STEP_CYCLES * (32'(ivl_f) - 32'd1));
  // channel set that a new run converts
  wire logic [7:0]  run_set = (mode_f == MODE_SINGLE) ?
                              ((8'h01 << chan_f) & SEQ_MASK) :
                              (seq_f & SEQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // register file; host write wins over the device clearing the mode
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl1_r <= CTRL1_RESET;
      ctrl2_r <= CTRL2_RESET;
      ctrl3_r <= CTRL3_RESET;
    end
    else
    begin
      if (wr_c1)
        ctrl1_r <= reg_req_in.wdata;
      else if (clr_mode)
        ctrl1_r[MODE_LSB +: 2] <= MODE_NONE;
      if (wr_c2)
        ctrl2_r <= reg_req_in.wdata;
      if (wr_c3)
        ctrl3_r <= reg_req_in.wdata;
    end
  end

  // registered read data; unmapped addresses read zero
  wire logic [15:0] rd_mux = (reg_req_in.addr == ADDR_CTRL1) ? ctrl1_r :
                             (reg_req_in.addr == ADDR_CTRL2) ? ctrl2_r :
                             (reg_req_in.addr == ADDR_CTRL3) ? ctrl3_r : 16'h0000;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rdata_r <= 16'h0000;
    else if (reg_req_in.rd)
      rdata_r <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // touch synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      touch_s1_r <= 1'b0;
      touch_s2_r <= 1'b0;
      touch_d_r  <= 1'b0;
    end
    else
    begin
      touch_s1_r <= touch_in;
      touch_s2_r <= touch_s1_r;
      touch_d_r  <= touch_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state machine
  always_comb
  begin
    state_nxt = state_r;
    pend_nxt  = pend_r;
    first_nxt = first_r;
    cnt_nxt   = (cnt_r != 20'h00000) ? (cnt_r - 20'h00001) : cnt_r;
    clr_mode  = 1'b0;
    conv_nxt  = '{start: 1'b0, chan: conv_r.chan, single_ended: conv_r.single_ended};
    case (state_r)
      ST_IDLE:
      begin
        // a fresh write of the mode field lands here and is acted on
        if (mode_f == MODE_SEQ_M)
          state_nxt = ST_ARM;
        else if (mode_f != MODE_NONE)
        begin
          pend_nxt  = run_set;
          first_nxt = 1'b1;
          state_nxt = ST_NEXT;
        end
      end
      ST_ARM:
      begin
        // only a new touch starts a master run
        if (touch_rise)
        begin
          pend_nxt  = run_set;
          first_nxt = 1'b1;
          state_nxt = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        if (pend_any && need_dly)
        begin
          cnt_nxt   = fdly_load;
          state_nxt = ST_PRE;
        end
        else if (pend_any)
        begin
          conv_nxt  = '{start: 1'b1, chan: next_ch, single_ended: se_f};
          state_nxt = ST_CONV;
        end
        else if (!first_r)
        begin
          cnt_nxt   = fdly_load;
          state_nxt = ST_POST;
        end
        else
        begin
          // nothing to convert (empty set or code 000): finish at once
          cnt_nxt = ivl_load;
          if (mode_f == MODE_SEQ_M)
            state_nxt = ST_ARM;
          else if (ivl_f == 8'h00)
          begin
            clr_mode  = 1'b1;
            state_nxt = ST_IDLE;
          end
          else
            state_nxt = ST_WAIT;
        end
      end
      ST_PRE:
      begin
        if (cnt_r == 20'h00000)
        begin
          conv_nxt  = '{start: 1'b1, chan: next_ch, single_ended: se_f};
          state_nxt = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (conv_done_in)
        begin
          pend_nxt[conv_r.chan] = 1'b0;
          first_nxt = 1'b0;
          state_nxt = ST_NEXT;
        end
      end
      ST_POST:
      begin
        if (cnt_r == 20'h00000)
        begin
          cnt_nxt = ivl_load;
          if (mode_f == MODE_SEQ_M)
            state_nxt = (touch_s && ivl_f != 8'h00) ? ST_WAIT : ST_ARM;
          else if (ivl_f == 8'h00)
          begin
            clr_mode  = 1'b1;
            state_nxt = ST_IDLE;
          end
          else
            state_nxt = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (mode_f == MODE_SEQ_M && !touch_s)
          state_nxt = ST_ARM;
        else if (cnt_r == 20'h00000)
        begin
          pend_nxt  = run_set;
          first_nxt = 1'b1;
          state_nxt = ST_NEXT;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
    // the host reprograms with mode 00 first; any write to ctrl1_r restarts cleanly
    if (wr_c1)
    begin
      state_nxt = ST_IDLE;
      pend_nxt  = 8'h00;
      conv_nxt.start = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= ST_IDLE;
      pend_r  <= 8'h00;
      first_r <= 1'b0;
      cnt_r   <= 20'h00000;
      conv_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      first_r <= first_nxt;
      cnt_r   <= cnt_nxt;
      conv_r  <= conv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pen / limit output, low active; busy flag
  wire logic pen_n_nxt = pen_dis_f ? !limit_alert_in : !touch_s;
  wire logic busy_nxt  = (state_nxt != ST_IDLE) && (state_nxt != ST_ARM);

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pen_n_r <= 1'b1;
      busy_r  <= 1'b0;
    end
    else
    begin
      pen_n_r <= pen_n_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign conv_req_out  = conv_r;
  assign reg_rdata_out = rdata_r;
  assign busy_out      = busy_r;
  assign pen_irq_n_out = pen_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_start_needs_mode: assert property (
    conv_r.start |-> $past(mode_f) != MODE_NONE)
    else $error("conversion started with mode 00");
  chk_single_chan: assert property (
    conv_r.start && $past(mode_f) == MODE_SINGLE |-> conv_r.chan == $past(chan_f))
    else $error("single conversion on wrong channel");
  chk_single_clear: assert property (
    state_r == ST_POST && cnt_r == 20'h00000 && mode_f == MODE_SINGLE
      && ivl_f == 8'h00 && !wr_c1 |=> mode_f == MODE_NONE && state_r == ST_IDLE)
    else $error("single mode not cleared after one conversion");
  chk_seq_member: assert property (
    conv_r.start && $past(mode_f) != MODE_SINGLE |-> seq_f[conv_r.chan])
    else $error("sequence converted an unselected channel");
  chk_no_invalid: assert property (
    conv_r.start |-> conv_r.chan != CH_INVALID)
    else $error("conversion issued for code 000");
  chk_method_bit: assert property (
    conv_r.start |-> conv_r.single_ended == $past(se_f))
    else $error("measurement method does not follow bit 9");
  chk_pen_touch: assert property (
    !pen_dis_f && touch_s ##1 !pen_dis_f |-> !pen_irq_n_out)
    else $error("pen output not low while touched");
  chk_arm_holds: assert property (
    state_r == ST_ARM && !touch_rise && !wr_c1 |=> state_r == ST_ARM)
    else $error("master run started without touch");
  chk_delay_len: assert property (
    state_r == ST_NEXT && state_nxt == ST_PRE
      |=> 32'(cnt_r) + 32'd1 == FDLY_UNIT_CYCLES * 32'(FDLY_MULT[$past(fdly_f)]))
    else $error("first conversion delay length wrong");
  chk_release_stop: assert property (
    state_r == ST_WAIT && mode_f == MODE_SEQ_M && !touch_s && !wr_c1 |=> state_r == ST_ARM)
    else $error("master timer kept running after release");

endmodule : tac_conv_ctrl

// >>> verif/tac_conv_model.sv
// converter core stand-in that answers every start with a done pulse
`timescale 1ns/1ns
module tac_conv_model
  import tac_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire tac_conv_req_type conv_req_in,
  input  wire logic             slow_in,
  output logic                  conv_done_out
);
  int cnt_r;

  // one conversion per start; slow mode checks that the block waits for done
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_r         <= 0;
      conv_done_out <= 1'b0;
    end
    else
    begin
      conv_done_out <= (cnt_r == 1);
      if (conv_req_in.start)
        cnt_r <= slow_in ? 9 : 2;
      else if (cnt_r > 0)
        cnt_r <= cnt_r - 1;
    end
  end
endmodule : tac_conv_model

// >>> verif/touch_adc_conversion_control_bench.sv
// self-checking bench for the touch adc conversion control block
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module touch_adc_conversion_control_bench;
  import tac_pkg::*;
  localparam int FU = 4;
  logic             clk_in;
  logic             sys_rst_in;
  logic             touch_in;
  logic             limit_in;
  logic             slow;
  logic             done;
  logic             busy;
  logic             pen_n;
  logic [15:0]      rdata;
  logic [15:0]      v;
  tac_reg_req_type  req;
  tac_conv_req_type conv;
  int               failures;
  int               cmp_count;
  int               cyc;
  int               t0;
  int               g [2];
  logic [3:0]       chq [$];
  int               tq [$];

  //////////////////////////////////////////////////////////////////////
  tac_conv_ctrl #(.FDLY_UNIT_CYCLES(FU), .IVL_BASE_CYCLES(20), .IVL_STEP_CYCLES(2))
    tac_conv_ctrl_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
    .conv_req_out(conv), .conv_done_in(done), .touch_in(touch_in),
    .limit_alert_in(limit_in), .reg_rdata_out(rdata), .busy_out(busy),
    .pen_irq_n_out(pen_n));
  tac_conv_model tac_conv_model_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .conv_req_in(conv), .slow_in(slow), .conv_done_out(done));

  // clock and start log, with the cycle of each start
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (conv.start === 1'b1)
    begin
      chq.push_back({conv.chan, conv.single_ended});
      tq.push_back(cyc);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register access; one request per call, gap after it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // start a run and wait, bounded, until it ends
  task automatic run(input logic [15:0] c1);
    int n;
    wr(ADDR_CTRL1, c1);
    repeat (4) @(posedge clk_in);
    for (n = 0; n < 3000 && busy !== 1'b0; n++)
      @(posedge clk_in);
    `CHK("run_end", 1'b0, busy)
  endtask : run
  task automatic wait_starts(input int n);
    for (int i = 0; i < 3000 && tq.size() < n; i++)
      @(posedge clk_in);
  endtask : wait_starts

  //////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(ADDR_CTRL1, v); `CHK("ctrl1_rst", 16'h0000, v)
    rd(ADDR_CTRL2, v); `CHK("ctrl2_rst", 16'h4040, v)
    wr(8'h0E, 16'hFFFF);
    rd(8'h0E, v); `CHK("unmapped", 16'h0000, v)
    wr(ADDR_CTRL2, 16'h4240);
    rd(ADDR_CTRL2, v); `CHK("ctrl2_rw", 16'h4240, v)
  endtask : t_regs
  // every channel code once, method bit alternating
  task automatic t_single;
    for (int c = 1; c < 8; c++)
    begin
      wr(ADDR_CTRL2, c[0] ? 16'h4240 : 16'h4040);
      chq.delete();
      run({1'b0, c[2:0], 2'b01, 10'h000});
      `CHK("single_n", 1, chq.size())
      `CHK("single_ch", {c[2:0], c[0]}, chq[0])
      rd(ADDR_CTRL1, v); `CHK("single_clr", {1'b0, c[2:0], 12'h000}, v)
    end
    chq.delete();
    run(16'h0400);
    `CHK("inval_n", 0, chq.size())
  endtask : t_single
  // full slow sequence, channel field must be ignored
  task automatic t_seq;
    wr(ADDR_CTRL2, 16'h4040);
    wr(ADDR_CTRL3, 16'h00FE);
    slow <= 1'b1;
    chq.delete();
    tq.delete();
    run(16'h3800);
    slow <= 1'b0;
    `CHK("seq_n", 7, chq.size())
    for (int i = 0; i < 7 && i < chq.size(); i++)
      `CHK("seq_ch", {3'(7 - i), 1'b0}, chq[i])
    if (tq.size() > 2)
      `CHK("xy_delay", FU, (tq[1] - tq[0]) - (tq[2] - tq[1]))
    rd(ADDR_CTRL1, v); `CHK("seq_clr", 16'h3000, v)
  endtask : t_seq
  // first delay at code 0 and code A differ by eleven units
  task automatic t_first_dly;
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CTRL2, i ? 16'h404A : 16'h4040);
      tq.delete();
      t0 = cyc;
      run(16'h3400);
      g[i] = tq.size() ? tq[0] - t0 : 0;
    end
    `CHK("first_dly_gap", 11 * FU, g[1] - g[0])
  endtask : t_first_dly
  // repeat interval for timer 1 and 3, run aborted by a host write
  task automatic t_timer;
    wr(ADDR_CTRL2, 16'h4040);
    for (int i = 0; i < 2; i++)
    begin
      tq.delete();
      wr(ADDR_CTRL1, {8'h34, 8'(1 + 2 * i)});
      wait_starts(2);
      g[i] = tq.size() > 1 ? tq[1] - tq[0] : 0;
      wr(ADDR_CTRL1, 16'h0000);
      repeat (60) @(posedge clk_in);
    end
    `CHK("ivl_rep", 1'b1, g[0] > 0)
    `CHK("ivl_step", 4, g[1] - g[0])
  endtask : t_timer
  task automatic t_master;
    wr(ADDR_CTRL3, 16'h0002);
    chq.delete();
    wr(ADDR_CTRL1, 16'h0C00);
    repeat (80) @(posedge clk_in);
    `CHK("m_armed", 0, chq.size())
    touch_in <= 1'b1;
    repeat (150) @(posedge clk_in);
    `CHK("m_once", 1, chq.size())
    touch_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    touch_in <= 1'b1;
    repeat (150) @(posedge clk_in);
    `CHK("m_fresh", 2, chq.size())
    // a held touch is not a fresh one: lift, rearm, then press again
    touch_in <= 1'b0;
    wr(ADDR_CTRL1, 16'h0000);
    wr(ADDR_CTRL1, 16'h0C01);
    repeat (4) @(posedge clk_in);
    touch_in <= 1'b1;
    repeat (300) @(posedge clk_in);
    `CHK("m_timer", 1'b1, chq.size() > 4)
    touch_in <= 1'b0;
    repeat (60) @(posedge clk_in);
    g[0] = chq.size();
    repeat (200) @(posedge clk_in);
    `CHK("m_stop", g[0], chq.size())
    wr(ADDR_CTRL1, 16'h0000);
  endtask : t_master
  // pen path latency, then limit path with pen disabled
  task automatic t_pen;
    @(posedge clk_in);
    touch_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 `CHK("pen_early", 1'b1, pen_n)
    @(posedge clk_in);
    #1 `CHK("pen_low", 1'b0, pen_n)
    wr(ADDR_CTRL1, 16'h8000);
    repeat (3) @(posedge clk_in);
    #1 `CHK("pen_off", 1'b1, pen_n)
    @(posedge clk_in);
    limit_in <= 1'b1;
    @(posedge clk_in);
    #1 `CHK("limit_low", 1'b0, pen_n)
    limit_in <= 1'b0;
    touch_in <= 1'b0;
    wr(ADDR_CTRL1, 16'h0000);
  endtask : t_pen

  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // main sequence and a watchdog sized well above its length
  initial
  begin
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    touch_in = 1'b0;
    limit_in = 1'b0;
    slow = 1'b0;
    req = '0;
    sys_rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_regs();
    t_single();
    t_seq();
    t_first_dly();
    t_timer();
    t_master();
    t_pen();
    tally_and_finish();
  end
  initial
  begin
    #(100 * 60000);
    failures++;
    tally_and_finish();
  end
endmodule : touch_adc_conversion_control_bench
